// ==== hdl/dpll_mode_defs.svh ====
/*
 * Constants of the DPLL mode and holdover control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 100 MHz I_MCLK and a 32-bit classic Wishbone master.
 */
// Contract
// RULE1: store frequency every 30 ms, alternating slots
// RULE2: holdover uses older slot, 30-60 ms old
// RULE3: holdover output from stored value only
// RULE4: holdover frequency equals stored word exactly
// RULE5: master clock drift passes through unattenuated
// RULE6: freerun uses master clock, ignores references
// RULE7: fast lock acquires eight times faster
// RULE8: fast lock plus SONET: slope below 1.9 ppm/s
// RULE9: host uses SDH filter until lock, then SONET
// RULE10: host keeps SONET and fast lock until lock
// RULE11: no lock in 16 s: host pulses holdover
// RULE12: brief holdover then normal clears phase error
// RULE13: selects: 00 normal, 01 hold, 10 free, 11 reserved
// RULE14: mode changes only on frame pulse rise
// RULE15: lock only if locked and no slope limiting
// RULE16: slots frozen unless normal and locked
`ifndef DPLL_MODE_DEFS_SVH
`define DPLL_MODE_DEFS_SVH

// ******************************
// register byte offsets
// ******************************
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_INT_STAT     8'h08
`define REG_INT_MASK     8'h0C
`define REG_HOLD_FREQ    8'h10
`define REG_NOMINAL_FREQ 8'h14

// ******************************
// field positions
// ******************************
`define CTRL_HOLD_BIT    0
`define CTRL_FREE_BIT    1
`define CTRL_FAST_BIT    2
`define CTRL_SONET_BIT   3
`define CTRL_WIDTH       4
`define STAT_LOCK_BIT    2
`define STAT_VALID_LSB   3
`define STAT_SLOPE_BIT   5
`define INT_WIDTH        4

// ******************************
// reset values
// ******************************
`define CTRL_RST         4'h2
`define NOMINAL_RST      32'h80000000
`define INT_MASK_RST     4'h0

// ******************************
// timing
// ******************************
`define MCLK_HZ          100000000
`define STORE_PERIOD_MS  30
`define FRAME_US         125
`define SLOPE_PPM_X10    19
`define FREQ_LSB_PER_PPM 1000000
`define FAST_LOCK_SHIFT  2'h3

`endif

// ==== hdl/dpll_mode_pkg.sv ====
/*
 * Types shared by the DPLL mode control files.
 * Assumes dpll_mode_defs.svh is compiled alongside.
 */
package dpll_mode_pkg;

    // ******************************
    // operating modes
    // ******************************
    typedef enum logic [1:0]
    {
        MODE_NORMAL,
        MODE_HOLDOVER,
        MODE_FREERUN
    } mode_type;

    // frequency word handed to the oscillator
    typedef logic [31:0] freq_type;

endpackage : dpll_mode_pkg

// ==== hdl/freq_store.sv ====
/*
 * Two-slot frequency store written alternately; recalls the older
 * sample. Assumes the caller gates i_store with the locked state.
 */
`timescale 1ns/1ps
`default_nettype none

module freq_store
    import dpll_mode_pkg::*;
(
    // clock and control
    input  wire logic     i_clk,
    input  wire logic     i_srst,
    input  wire logic     i_ce,
    // sample in
    input  wire logic     i_store,
    input  wire freq_type i_word,
    input  wire freq_type i_fallback,
    // recall out
    output freq_type      o_recall,
    output logic [1:0]    o_valid
);

    freq_type slot [2];   // sample storage
    logic     wr_idx;     // slot written next, also the older one

    // ******************************
    // slot writes
    // ******************************
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_slot
            // each slot loads only on its own turn
            always_ff @(posedge i_clk)
            begin
                if (i_srst)
                begin
                    slot[g]    <= '0;
                    o_valid[g] <= 1'b0;
                end
                else if (i_ce && i_store && (wr_idx == 1'(g)))
                begin
                    slot[g]    <= i_word;   // [RULE1]
                    o_valid[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // alternate slots on every store
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            wr_idx <= 1'b0;
        else if (i_ce && i_store)
            wr_idx <= ~wr_idx;   // [RULE1]
    end

    // older slot first; newest only if no older exists yet
    always_comb
    begin
        if (o_valid[wr_idx])
            o_recall = slot[wr_idx];   // [RULE2]
        else if (o_valid[~wr_idx])
            o_recall = slot[~wr_idx];
        else
            o_recall = i_fallback;
    end

endmodule : freq_store

`default_nettype wire

// ==== hdl/dpll_mode_ctrl.sv ====
/*
 * Mode control of a DPLL synchronizer: normal, holdover and freerun
 * selection, holdover storage, fast lock gain and slope limit, lock
 * indication, Wishbone registers and an interrupt.
 * Assumes loop inputs and the frame pulse come from logic on I_MCLK.
 */
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "dpll_mode_defs.svh"

module dpll_mode_ctrl
    import dpll_mode_pkg::*;
#(
    parameter int STORE_CYCLES = `STORE_PERIOD_MS * (`MCLK_HZ / 1000)
)
(
    // clock, reset, enable
    input  wire logic        I_MCLK,
    input  wire logic        I_SRST,
    input  wire logic        I_CE,
    // wishbone slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [7:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    // loop status
    input  wire logic        I_FRAME_PULSE_8K,
    input  wire freq_type    I_LOOP_FREQ,
    input  wire logic        I_FREQ_LOCKED,
    input  wire logic        I_SLOPE_LIMITING,
    // loop control
    output var mode_type     O_MODE,
    output freq_type         O_DCO_FREQ,
    output logic             O_TRACK_REF,
    output logic [1:0]       O_GAIN_SHIFT,
    output logic             O_SONET_FILTER,
    output logic             O_PHASE_CLEAR,
    output logic             O_LOCK,
    // interrupt
    output logic             O_INT
);

    // ******************************
    // constants
    // ******************************
    localparam int STEP_INT = (`SLOPE_PPM_X10 * (`FREQ_LSB_PER_PPM / 10))
                              * `FRAME_US / 1000000;
    localparam logic [32:0] SLOPE_STEP = 33'(STEP_INT);
    localparam logic [21:0] STORE_LAST = 22'(STORE_CYCLES - 1);

    // ******************************
    // declarations
    // ******************************
    logic [`CTRL_WIDTH-1:0] ctrl;        // mode selects, fast, sonet
    logic [`INT_WIDTH-1:0]  int_stat;    // sticky events
    logic [`INT_WIDTH-1:0]  int_mask;    // interrupt enables
    logic [`INT_WIDTH-1:0]  event_vec;   // this cycle's events
    freq_type               nominal;     // freerun word
    freq_type               recall;      // older stored sample
    logic [1:0]             slot_valid;  // stored samples present
    logic                   frame_prev;  // frame pulse delayed
    logic                   frame_rise;  // frame pulse rising edge
    logic [21:0]            store_cnt;   // cycles since last sample
    logic                   store_ok;    // normal and locked
    logic                   store_pulse; // sample now
    logic                   slope_on;    // slope limit engaged
    logic                   lock_d;      // lock delayed
    mode_type               mode_d;      // mode delayed
    mode_type               next_mode;   // decoded request
    logic                   wb_req;      // bus cycle present
    logic                   wb_wr;       // write commits this edge
    logic [31:0]            wmask;       // byte lane mask
    logic [31:0]            rd_word;     // read mux

    // ******************************
    // functions
    // ******************************
    // byte enables to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++)
            m[b*8 +: 8] = {8{sel[b]}};
        return m;
    endfunction : lane_mask

    // mode select pair; reserved code keeps the current mode
    function automatic mode_type decode_mode(input logic hold,
                                             input logic free,
                                             input mode_type cur);
        unique case ({free, hold})
            2'h0:    return MODE_NORMAL;
            2'h1:    return MODE_HOLDOVER;
            2'h2:    return MODE_FREERUN;
            default: return cur;
        endcase
    endfunction : decode_mode

    // move one slope step toward the target word
    function automatic freq_type slew(input freq_type cur,
                                      input freq_type tgt);
        logic [32:0] diff;
        diff = {1'b0, tgt} - {1'b0, cur};
        if (tgt >= cur)
            return (diff > SLOPE_STEP) ? cur + SLOPE_STEP[31:0] : tgt;
        else
            return ((-diff) > SLOPE_STEP) ? cur - SLOPE_STEP[31:0] : tgt;
    endfunction : slew

    // ******************************
    // frame edge and mode state
    // ******************************
    assign frame_rise = I_FRAME_PULSE_8K & ~frame_prev;
    assign next_mode  = decode_mode(ctrl[`CTRL_HOLD_BIT],
                                    ctrl[`CTRL_FREE_BIT], O_MODE);

    // frame pulse history
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
            frame_prev <= 1'b0;
        else if (I_CE)
            frame_prev <= I_FRAME_PULSE_8K;
    end

    // mode moves only on a frame edge, so outputs switch cleanly
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
            O_MODE <= MODE_FREERUN;
        else if (I_CE && frame_rise)
            O_MODE <= next_mode;   // [RULE13] [RULE14]
    end

    // ******************************
    // holdover storage
    // ******************************
    assign store_ok    = (O_MODE == MODE_NORMAL) && O_LOCK;   // [RULE16]
    assign store_pulse = store_ok && (store_cnt == STORE_LAST);

    // sample timer restarts whenever lock or normal mode is lost
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
            store_cnt <= '0;
        else if (I_CE)
        begin
            if (!store_ok || store_pulse)
                store_cnt <= '0;   // [RULE16]
            else
                store_cnt <= store_cnt + 22'h1;   // [RULE1]
        end
    end

    freq_store u_store
    (
        .i_clk      (I_MCLK),
        .i_srst     (I_SRST),
        .i_ce       (I_CE),
        .i_store    (store_pulse),
        .i_word     (O_DCO_FREQ),
        .i_fallback (nominal),
        .o_recall   (recall),
        .o_valid    (slot_valid)
    );

    // ******************************
    // oscillator drive
    // ******************************
    assign slope_on = (O_MODE == MODE_NORMAL) && ctrl[`CTRL_FAST_BIT]
                      && ctrl[`CTRL_SONET_BIT];

    // word is passed as is unless slope limited; master clock drift is not corrected
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
            O_DCO_FREQ <= `NOMINAL_RST;
        else if (I_CE)
        begin
            unique case (O_MODE)
                MODE_NORMAL:
                begin
                    if (!slope_on)
                        O_DCO_FREQ <= I_LOOP_FREQ;
                    else if (frame_rise)
                        O_DCO_FREQ <= slew(O_DCO_FREQ, I_LOOP_FREQ); // [RULE8]
                end
                MODE_HOLDOVER:
                    O_DCO_FREQ <= recall;   // [RULE2] [RULE3] [RULE4] [RULE5]
                MODE_FREERUN:
                    O_DCO_FREQ <= nominal;  // [RULE6]
            endcase
        end
    end

    // loop control outputs
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            O_TRACK_REF    <= 1'b0;
            O_GAIN_SHIFT   <= 2'h0;
            O_SONET_FILTER <= 1'b0;
            O_PHASE_CLEAR  <= 1'b0;
        end
        else if (I_CE)
        begin
            O_TRACK_REF    <= (O_MODE == MODE_NORMAL);   // [RULE3] [RULE6]
            O_GAIN_SHIFT   <= (slope_on || ((O_MODE == MODE_NORMAL)
                               && ctrl[`CTRL_FAST_BIT]))
                              ? `FAST_LOCK_SHIFT : 2'h0;   // [RULE7]
            O_SONET_FILTER <= ctrl[`CTRL_SONET_BIT];
            // leaving holdover for normal drops accumulated phase
            O_PHASE_CLEAR  <= (mode_d == MODE_HOLDOVER)
                              && (O_MODE == MODE_NORMAL);   // [RULE12]
        end
    end

    // lock only when frequency locked with no slope limiting
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
            O_LOCK <= 1'b0;
        else if (I_CE)
            O_LOCK <= I_FREQ_LOCKED && !I_SLOPE_LIMITING
                      && (O_MODE == MODE_NORMAL);   // [RULE15]
    end

    // ******************************
    // events and interrupt
    // ******************************
    assign event_vec = {store_pulse, (O_MODE != mode_d),
                        lock_d & ~O_LOCK, O_LOCK & ~lock_d};

    // history for event edges
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            lock_d <= 1'b0;
            mode_d <= MODE_FREERUN;
        end
        else if (I_CE)
        begin
            lock_d <= O_LOCK;
            mode_d <= O_MODE;
        end
    end

    // sticky status; a new event wins over a one-write clear
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
            int_stat <= '0;
        else if (I_CE)
        begin
            if (wb_wr && (I_WB_ADR == `REG_INT_STAT))
                int_stat <= (int_stat & ~(I_WB_DAT[`INT_WIDTH-1:0]
                                          & wmask[`INT_WIDTH-1:0]))
                            | event_vec;
            else
                int_stat <= int_stat | event_vec;
        end
    end

    // level interrupt from a flop
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
            O_INT <= 1'b0;
        else if (I_CE)
            O_INT <= |(int_stat & int_mask);
    end

    // ******************************
    // wishbone slave
    // ******************************
    assign wb_req = I_WB_CYC && I_WB_STB;
    assign wb_wr  = wb_req && I_WB_WE && O_WB_ACK;   // commit at ack edge
    assign wmask  = lane_mask(I_WB_SEL);

    // software registers
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            ctrl     <= `CTRL_RST;
            int_mask <= `INT_MASK_RST;
            nominal  <= `NOMINAL_RST;
        end
        else if (I_CE && wb_wr)
        begin
            unique case (I_WB_ADR)
                `REG_CTRL:
                    ctrl <= (ctrl & ~wmask[`CTRL_WIDTH-1:0])
                            | (I_WB_DAT[`CTRL_WIDTH-1:0]
                               & wmask[`CTRL_WIDTH-1:0]);
                `REG_INT_MASK:
                    int_mask <= (int_mask & ~wmask[`INT_WIDTH-1:0])
                                | (I_WB_DAT[`INT_WIDTH-1:0]
                                   & wmask[`INT_WIDTH-1:0]);
                `REG_NOMINAL_FREQ:
                    nominal <= (nominal & ~wmask) | (I_WB_DAT & wmask);
                default:
                    nominal <= nominal;   // read-only, unmapped, or interrupt status written above
            endcase
        end
    end

    // read mux; unmapped reads as zero
    always_comb
    begin
        rd_word = '0;
        unique case (I_WB_ADR)
            `REG_CTRL:         rd_word[`CTRL_WIDTH-1:0] = ctrl;
            `REG_STATUS:
            begin
                rd_word[1:0]                 = O_MODE;
                rd_word[`STAT_LOCK_BIT]      = O_LOCK;
                rd_word[`STAT_VALID_LSB +: 2] = slot_valid;
                rd_word[`STAT_SLOPE_BIT]     = slope_on;
            end
            `REG_INT_STAT:     rd_word[`INT_WIDTH-1:0] = int_stat;
            `REG_INT_MASK:     rd_word[`INT_WIDTH-1:0] = int_mask;
            `REG_HOLD_FREQ:    rd_word = recall;
            `REG_NOMINAL_FREQ: rd_word = nominal;
            default:           rd_word = '0;
        endcase
    end

    // ack one cycle after the request, dropped the next cycle
    always_ff @(posedge I_MCLK)
    begin
        if (I_SRST)
        begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= '0;
        end
        else if (I_CE)
        begin
            O_WB_ACK <= wb_req && !O_WB_ACK;
            if (wb_req && !O_WB_ACK)
                O_WB_DAT <= rd_word;
        end
    end

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SRST || !I_CE);

    sequence hold_then_normal_s;
        (O_MODE == MODE_HOLDOVER) ##1 (O_MODE == MODE_NORMAL);
    endsequence

    sequence slope_two_s;
        slope_on ##1 slope_on;
    endsequence

    mode_on_frame_a: assert property ( // [RULE14]
        (O_MODE != $past(O_MODE)) |-> $past(frame_rise))
        else $error("mode changed without frame edge");

    mode_decode_a: assert property ( // [RULE13]
        (frame_rise && ctrl[1:0] == 2'h1) |=> (O_MODE == MODE_HOLDOVER))
        else $error("holdover select not decoded");

    hold_recall_a: assert property ( // [RULE2]
        (O_MODE == MODE_HOLDOVER) ##1 (O_MODE == MODE_HOLDOVER)
        |-> (O_DCO_FREQ == $past(recall)))
        else $error("holdover word not recalled");

    freerun_out_a: assert property ( // [RULE6]
        (O_MODE == MODE_FREERUN) |=> (O_DCO_FREQ == $past(nominal))
        && !O_TRACK_REF)
        else $error("freerun not from nominal");

    store_period_a: assert property ( // [RULE1]
        store_pulse |=> (slot_valid != 2'h0))
        else $error("sample not stored");

    store_freeze_a: assert property ( // [RULE16]
        !store_ok |=> (store_cnt == 22'h0) && !store_pulse)
        else $error("sampling while not locked");

    lock_cause_a: assert property ( // [RULE15]
        O_LOCK |-> $past(I_FREQ_LOCKED) && !$past(I_SLOPE_LIMITING))
        else $error("lock without frequency lock");

    fast_gain_a: assert property ( // [RULE7]
        (O_MODE == MODE_NORMAL && ctrl[`CTRL_FAST_BIT])
        |=> (O_GAIN_SHIFT == 2'h3))
        else $error("fast lock gain missing");

    slope_step_a: assert property ( // [RULE8]
        slope_two_s |-> ((O_DCO_FREQ >= $past(O_DCO_FREQ))
            ? (O_DCO_FREQ - $past(O_DCO_FREQ) <= SLOPE_STEP[31:0])
            : ($past(O_DCO_FREQ) - O_DCO_FREQ <= SLOPE_STEP[31:0])))
        else $error("frequency slope too steep");

    phase_clear_a: assert property ( // [RULE12]
        hold_then_normal_s |=> O_PHASE_CLEAR)
        else $error("phase error not cleared");

endmodule : dpll_mode_ctrl

`default_nettype wire

// ==== sim/loop_partner.sv ====
/*
 * Stand-in for the loop and frame logic beside the mode block.
 * Assumes the bench steers the loop word, lock and slope flags.
 */
`timescale 1ns/1ps
`default_nettype none

module loop_partner
#(
    parameter int FRAME_CYC = 16
)
(
    // clock
    input  wire logic        i_clk,
    // bench steering
    input  wire logic [31:0] i_target,
    input  wire logic        i_locked,
    input  wire logic        i_slope,
    // toward the block
    output logic             o_frame,
    output logic [31:0]      o_freq,
    output logic             o_locked,
    output logic             o_slope
);
    int cnt = 0; // frame divider

    // two-cycle frame pulse; short period keeps the run brief
    always_ff @(posedge i_clk)
    begin
        cnt     <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
        o_frame <= (cnt < 2);
    end

    // loop word and flags pass straight through
    assign o_freq   = i_target;
    assign o_locked = i_locked;
    assign o_slope  = i_slope;
endmodule : loop_partner

`default_nettype wire

// ==== sim/tb.sv ====
/*
 * Self-checking bench of the mode block, acting as host.
 * Assumes the loop partner makes the frame pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpll_mode_defs.svh"

module tb;
    import dpll_mode_pkg::*;
    // ******************************
    // signals
    // ******************************
    logic        clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, ce = 1;
    logic [7:0]  adr = '0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = '0, rdat, tgt = 32'h80000000, d0;
    logic        locked = 0, slope = 0;
    wire logic        frame, llock, lslope, ack, track, sonet, pclr, lock, irq;
    wire logic [31:0] lfreq, rd_dat, dco;
    wire logic [1:0]  gain;
    mode_type         mode;
    int n_mismatch = 0, checks = 0, cycles = 0, n_pclr = 0;

    always #5 clk = ~clk;

    loop_partner i_loop_partner (.i_clk(clk), .i_target(tgt), .i_locked(locked),
        .i_slope(slope), .o_frame(frame), .o_freq(lfreq), .o_locked(llock),
        .o_slope(lslope));

    dpll_mode_ctrl #(.STORE_CYCLES(20)) i_dpll_mode_ctrl (.I_MCLK(clk), .I_SRST(srst),
        .I_CE(ce), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
        .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rd_dat), .O_WB_ACK(ack),
        .I_FRAME_PULSE_8K(frame), .I_LOOP_FREQ(lfreq), .I_FREQ_LOCKED(llock),
        .I_SLOPE_LIMITING(lslope), .O_MODE(mode), .O_DCO_FREQ(dco),
        .O_TRACK_REF(track), .O_GAIN_SHIFT(gain), .O_SONET_FILTER(sonet),
        .O_PHASE_CLEAR(pclr), .O_LOCK(lock), .O_INT(irq));

    // ******************************
    // helpers
    // ******************************
    // timeout and pulse counter
    always @(posedge clk)
    begin
        cycles++;
        if (pclr === 1'b1)
            n_pclr++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // compare one word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        if (got !== exp)
            n_mismatch++;
    endtask : chk

    // one classic single cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1);
        chk(n, 32'h2); // ack seen at the second edge
        rdat = rd_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // write selects between frames; applied only at the next frame rise
    task automatic setmode(input logic [3:0] c, input mode_type was);
        @(posedge frame);
        @(posedge clk);
        wb(1'b1, `REG_CTRL, {28'h0, c});
        chk({30'h0, mode}, {30'h0, was});
        @(posedge frame);
        repeat (4) @(posedge clk);
    endtask : setmode

    // clear stored-sample flag, wait for the next one
    task automatic store_wait();
        int n;
        wb(1'b1, `REG_INT_STAT, 32'h8);
        @(posedge clk);
        for (n = 0; n < 60 && irq !== 1'b1; n++)
            @(posedge clk);
        chk({31'h0, irq}, 32'h1);
    endtask : store_wait

    // ******************************
    // scenarios
    // ******************************
    task automatic t_reset();
        chk({30'h0, mode}, {30'h0, MODE_FREERUN});
        chk({31'h0, track}, 32'h0);
        chk({31'h0, lock}, 32'h0);
        wb(1'b0, `REG_CTRL, 32'h0);
        chk(rdat, 32'h2);
        wb(1'b0, `REG_NOMINAL_FREQ, 32'h0);
        chk(rdat, 32'h80000000);
        wb(1'b0, 8'h1C, 32'h0);
        chk(rdat, 32'h0);
    endtask : t_reset

    // normal in SDH setting; lock follows loop flags
    task automatic t_normal();
        setmode(4'h0, MODE_FREERUN);
        chk({30'h0, mode}, {30'h0, MODE_NORMAL});
        chk({31'h0, track}, 32'h1);
        chk({31'h0, lock}, 32'h1);
        slope <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, lock}, 32'h0);
        slope <= 1'b0;
    endtask : t_normal

    // older slot recalled on holdover, frozen when unlocked
    task automatic t_store();
        wb(1'b1, `REG_INT_MASK, 32'h8);
        tgt <= 32'h80001234;
        repeat (3) store_wait();
        tgt <= 32'h80005678;
        repeat (3) @(posedge clk);
        store_wait();
        locked <= 1'b0;
        repeat (3) @(posedge clk);
        setmode(4'h1, MODE_NORMAL);
        chk({30'h0, mode}, {30'h0, MODE_HOLDOVER});
        chk(dco, 32'h80001234);
        chk({31'h0, track}, 32'h0);
        tgt <= 32'h80101234;
        repeat (5) @(posedge clk);
        chk(dco, 32'h80001234);
        wb(1'b0, `REG_HOLD_FREQ, 32'h0);
        chk(rdat, 32'h80001234);
        wb(1'b0, `REG_STATUS, 32'h0);
        chk(rdat, 32'h00000019);
    endtask : t_store

    // back to normal with fast lock and SONET held on
    task automatic t_return();
        int p;
        locked <= 1'b1;
        p = n_pclr;
        setmode(4'hC, MODE_HOLDOVER);
        @(posedge clk);
        chk(n_pclr, p + 1);
        chk({30'h0, gain}, 32'h3);
        chk({31'h0, sonet}, 32'h1);
        d0 = dco;
        @(posedge frame);
        repeat (4) @(posedge clk);
        chk(dco - d0, 32'h000000ED);
    endtask : t_return

    // reserved select keeps mode; freerun drops tracking and lock
    task automatic t_reserved();
        setmode(4'h3, MODE_NORMAL);
        chk({30'h0, mode}, {30'h0, MODE_NORMAL});
        setmode(4'h2, MODE_NORMAL);
        chk({30'h0, mode}, {30'h0, MODE_FREERUN});
        chk({31'h0, track}, 32'h0);
        chk({31'h0, lock}, 32'h0);
    endtask : t_reserved

    // mode-change flag: raise, mask, clear
    task automatic t_irq();
        wb(1'b1, `REG_INT_MASK, 32'h4);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, `REG_INT_MASK, 32'h0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, `REG_INT_MASK, 32'h4);
        wb(1'b1, `REG_INT_STAT, 32'h4);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, `REG_INT_STAT, 32'h0);
        chk(rdat, 32'h0000000B); // other sticky bits survive
    endtask : t_irq

    // frozen enable holds the mode across a frame edge
    task automatic t_freeze();
        @(posedge frame);
        @(posedge clk);
        wb(1'b1, `REG_CTRL, 32'h0);
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        chk({30'h0, mode}, {30'h0, MODE_FREERUN});
        ce <= 1'b1;
        @(posedge frame);
        repeat (4) @(posedge clk);
        chk({30'h0, mode}, {30'h0, MODE_NORMAL});
    endtask : t_freeze

    // ******************************
    // main sequence
    // ******************************
    initial
    begin
        repeat (5) @(posedge clk);
        srst   <= 1'b0;
        locked <= 1'b1;
        @(posedge clk);
        t_reset();
        t_normal();
        t_store();
        t_return();
        t_reserved();
        t_irq();
        t_freeze();
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
